//--- dpoc_byte_reg.sv
`timescale 1ns/1ns

module dpoc_byte_reg #(
    parameter logic [7:0] MASK = 8'hff,
    parameter logic [7:0] RST  = 8'h00
) (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       clr_in,
    input  wire logic       we_in,
    input  wire logic [7:0] d_in,
    output logic [7:0]      q_out
);
    logic [7:0] q_r;

    // soft clear beats a write in the same cycle so a reset write is never half undone
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in || clr_in)
            q_r <= RST & MASK;
        else if (we_in)
            q_r <= d_in & MASK;
    end

    assign q_out = q_r;

endmodule

//--- dpoc_cfg_bank.sv
`timescale 1ns/1ns
`include "dpoc_regs.svh"

// =====================================================================
// Overview of operation
// - loop config bit 7 powers the loop off; bit 5 powers its divider off.
// - bits 4:3 give divide by 2/4/8 (11 invalid) or delay 130 to 580 ps.
// - bit 0 inverts the sample clock edge, with the loop on or off.
// - frequency word bytes 7:0 to 31:24 come from addresses 03h to 06h.
// - phase word low byte from the low register, high byte from high.
// - channel A first register: bit 7 powers off, bit 6 enables sleep.
// - channel A offset is 11 bits: low five in 5:1, upper six at 0Bh.
// - channel A coarse gain: bits 1:0 at 0Ah 7:6, bits 3:2 at 0Bh 7:6.
// - channel A fine gain is bits 5:0 of 0Ah.
// - channel B register 0Ch: bit 7 powers off, bit 6 enables sleep.
// - channel B offset: low five from 0Ch 5:1, upper six from 0Eh 5:0.
// - channel B coarse gain: bits 1:0 at 0Dh 7:6, bits 3:2 at 0Eh 7:6.
// - channel B fine gain is bits 5:0 of 0Dh.
// - low power oscillator uses only five top bits of 06h and 08h.
// - clearing oscillator enable stops it and zeroes its accumulator; output phase then shows the phase word (its top five bits in low power).
// - interface reset returns every byte register of this bank to default.
module dpoc_cfg_bank
    import dpoc_pkg::*;
(
    input  wire logic           clk_in,
    input  wire logic           rstn_in,
    input  wire dpoc_reg_req_t  req_in,
    input  wire logic           soft_reset_in,
    input  wire logic           osc_enable_in,
    input  wire logic           osc_low_power_sel_in,
    output logic [7:0]          rdata_out,
    output dpoc_loop_cfg_t      loop_cfg_out,
    output dpoc_chan_cfg_t      chan_a_out,
    output dpoc_chan_cfg_t      chan_b_out,
    output logic [31:0]         osc_freq_word_out,
    output logic [15:0]         osc_phase_word_out,
    output logic [15:0]         osc_phase_out
);

    // =================================================================
    // register table
    localparam int NREG = 13;

    localparam logic [7:0] REG_ADDR [NREG] = '{
        `DPOC_ADDR_LOOP,   `DPOC_ADDR_FREQ0,  `DPOC_ADDR_FREQ1,  `DPOC_ADDR_FREQ2,
        `DPOC_ADDR_FREQ3,  `DPOC_ADDR_PH_LO,  `DPOC_ADDR_PH_HI,  `DPOC_ADDR_A_CFG1,
        `DPOC_ADDR_A_CFG2, `DPOC_ADDR_A_CFG3, `DPOC_ADDR_B_CFG1, `DPOC_ADDR_B_CFG2,
        `DPOC_ADDR_B_CFG3
    };

    // reserved positions are masked at the write so they can never read back set
    localparam logic [7:0] REG_MASK [NREG] = '{
        `DPOC_MASK_LOOP, `DPOC_MASK_FULL, `DPOC_MASK_FULL, `DPOC_MASK_FULL,
        `DPOC_MASK_FULL, `DPOC_MASK_FULL, `DPOC_MASK_FULL, `DPOC_MASK_CFG1,
        `DPOC_MASK_FULL, `DPOC_MASK_FULL, `DPOC_MASK_CFG1, `DPOC_MASK_FULL,
        `DPOC_MASK_FULL
    };

    logic [7:0]      reg_q [NREG];
    logic [NREG-1:0] reg_we;
    logic [7:0]      rdata_nxt;
    logic [7:0]      rdata_r;
    dpoc_loop_cfg_t  loop_nxt;
    dpoc_loop_cfg_t  loop_r;
    logic [7:0]      lp;
    logic [7:0]      a1;
    logic [7:0]      a2;
    logic [7:0]      a3;
    logic [7:0]      b1;
    logic [7:0]      b2;
    logic [7:0]      b3;

    // =================================================================
    // byte registers, one per address
    // each register only sees its own strobe, so multi-byte words change a byte at a time
    for (genvar i = 0; i < NREG; i++)
    begin : g_reg
        assign reg_we[i] = req_in.wr && (req_in.addr == REG_ADDR[i]);

        dpoc_byte_reg #(
            .MASK (REG_MASK[i]),
            .RST  (`DPOC_RST_BYTE)
        ) u_reg (
            .clk_in  (clk_in),
            .rstn_in (rstn_in),
            .clr_in  (soft_reset_in),
            .we_in   (reg_we[i]),
            .d_in    (req_in.wdata),
            .q_out   (reg_q[i])
        );
    end

    // =================================================================
    // read path
    // unmapped addresses answer zero rather than holding the last value
    always_comb
    begin
        rdata_nxt = 8'h00;
        for (int k = 0; k < NREG; k++)
        begin
            if (req_in.addr == REG_ADDR[k])
                rdata_nxt = reg_q[k];
        end
    end

    // read data registered one cycle after the strobe, held until the next read
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            rdata_r <= 8'h00;
        else if (req_in.rd)
            rdata_r <= rdata_nxt;
    end

    assign rdata_out = rdata_r;

    // =================================================================
    // short names for the configuration bytes
    assign lp = reg_q[IDX_LOOP];
    assign a1 = reg_q[IDX_A_CFG1];
    assign a2 = reg_q[IDX_A_CFG2];
    assign a3 = reg_q[IDX_A_CFG3];
    assign b1 = reg_q[IDX_B_CFG1];
    assign b2 = reg_q[IDX_B_CFG2];
    assign b3 = reg_q[IDX_B_CFG3];

    // =================================================================
    // clock synthesis loop decode
    // both meanings of the divider field are decoded; the user picks by loop state
    always_comb
    begin
        loop_nxt                          = '0;
        loop_nxt.synth_loop_off           = lp[`DPOC_LOOP_OFF_BIT];
        loop_nxt.loop_divider_off         = lp[`DPOC_DIV_OFF_BIT];
        loop_nxt.sample_clock_edge_invert = lp[`DPOC_EDGE_BIT];
        case (lp[`DPOC_DIV_HI:`DPOC_DIV_LO])
            2'b00:
            begin
                loop_nxt.div_ratio    = 4'h2;
                loop_nxt.clk_delay_ps = `DPOC_DLY0_PS;
            end
            2'b01:
            begin
                loop_nxt.div_ratio    = 4'h4;
                loop_nxt.clk_delay_ps = `DPOC_DLY1_PS;
            end
            2'b10:
            begin
                loop_nxt.div_ratio    = 4'h8;
                loop_nxt.clk_delay_ps = `DPOC_DLY2_PS;
            end
            default:
            begin
                // code 11 has no divider meaning; flag it instead of guessing a ratio
                loop_nxt.div_ratio        = 4'h0;
                loop_nxt.div_code_invalid = !lp[`DPOC_LOOP_OFF_BIT];
                loop_nxt.clk_delay_ps     = `DPOC_DLY3_PS;
            end
        endcase
        case (lp[`DPOC_PHS_HI:`DPOC_PHS_LO])
            2'b01:   loop_nxt.phase_shift_deg = `DPOC_PHS1_DEG;
            2'b10:   loop_nxt.phase_shift_deg = `DPOC_PHS2_DEG;
            default: loop_nxt.phase_shift_deg = 9'h000;
        endcase
    end

    // decoded loop settings come from flip-flops, one cycle behind the register
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            loop_r <= '0;
        else
            loop_r <= loop_nxt;
    end

    assign loop_cfg_out = loop_r;

    // =================================================================
    // channel field assembly
    always_comb
    begin
        chan_a_out.power_off   = a1[`DPOC_PWR_BIT];
        chan_a_out.sleep       = a1[`DPOC_SLEEP_BIT];
        chan_a_out.offset      = {a3[5:0], a1[5:1]};
        chan_a_out.gain_coarse = {a3[7:6], a2[7:6]};
        chan_a_out.gain_fine   = a2[5:0];
        chan_b_out.power_off   = b1[`DPOC_PWR_BIT];
        chan_b_out.sleep       = b1[`DPOC_SLEEP_BIT];
        chan_b_out.offset      = {b3[5:0], b1[5:1]};
        chan_b_out.gain_coarse = {b3[7:6], b2[7:6]};
        chan_b_out.gain_fine   = b2[5:0];
    end

    // =================================================================
    // oscillator words and accumulator
    // the word is not shadowed: a multi-byte update is seen byte by byte
    assign osc_freq_word_out  = {reg_q[IDX_FREQ3], reg_q[IDX_FREQ2],
                                 reg_q[IDX_FREQ1], reg_q[IDX_FREQ0]};
    assign osc_phase_word_out = {reg_q[IDX_PH_HI], reg_q[IDX_PH_LO]};

    dpoc_osc_accum #(
        .ACC_W (32),
        .PH_W  (16)
    ) u_osc (
        .clk_in               (clk_in),
        .rstn_in              (rstn_in),
        .osc_enable_in        (osc_enable_in),
        .osc_low_power_sel_in (osc_low_power_sel_in),
        .freq_word_in         (osc_freq_word_out),
        .phase_word_in        (osc_phase_word_out),
        .phase_out            (osc_phase_out)
    );

    // =================================================================
    // checks
    default clocking cb @(posedge clk_in);
    endclocking

    default disable iff (!rstn_in);

    AST_LOOP_POWER: assert property (
        (req_in.wr && req_in.addr == `DPOC_ADDR_LOOP && !soft_reset_in) |-> ##2
        (loop_cfg_out.synth_loop_off == $past(req_in.wdata[7], 2)) &&
        (loop_cfg_out.loop_divider_off == $past(req_in.wdata[5], 2)))
        else $error("loop power bits not taken from the written byte");

    AST_DIV_CODE: assert property (
        (lp[4:3] == 2'b01 && !lp[7]) |=> (loop_cfg_out.div_ratio == 4'h4))
        else $error("divider code 01 does not give divide by four");

    AST_DELAY_CODE: assert property (
        (lp[4:3] == 2'b11) |=> (loop_cfg_out.clk_delay_ps == 10'd580) &&
        (loop_cfg_out.div_ratio == 4'h0))
        else $error("divider code 11 decoded wrongly");

    AST_PHASE_SHIFT: assert property (
        (lp[2:1] == 2'b10) |=> (loop_cfg_out.phase_shift_deg == 9'd240))
        else $error("phase code 10 does not give 240 degrees");

    AST_EDGE: assert property (
        $changed(lp[0]) |=> (loop_cfg_out.sample_clock_edge_invert == $past(lp[0])))
        else $error("sample clock edge not following its bit");

    AST_FREQ_TOP: assert property (
        (req_in.wr && req_in.addr == `DPOC_ADDR_FREQ3 && !soft_reset_in) |=>
        (osc_freq_word_out[31:24] == $past(req_in.wdata)) && $stable(osc_freq_word_out[23:0]))
        else $error("frequency top byte not written alone");

    AST_PHASE_LOW: assert property (
        (req_in.wr && req_in.addr == `DPOC_ADDR_PH_LO && !soft_reset_in) |=>
        (osc_phase_word_out[7:0] == $past(req_in.wdata)) && $stable(osc_phase_word_out[15:8]))
        else $error("phase low byte not written alone");

    AST_CHAN_A_CFG1: assert property (
        (req_in.wr && req_in.addr == `DPOC_ADDR_A_CFG1 && !soft_reset_in) |=>
        (chan_a_out.power_off == $past(req_in.wdata[7])) && (chan_a_out.sleep == $past(req_in.wdata[6])) &&
        (chan_a_out.offset[4:0] == $past(req_in.wdata[5:1])))
        else $error("channel A first register fields wrong");

    AST_CHAN_A_HIGH: assert property (
        (req_in.wr && req_in.addr == `DPOC_ADDR_A_CFG3 && !soft_reset_in) |=>
        (chan_a_out.gain_coarse[3:2] == $past(req_in.wdata[7:6])) &&
        (chan_a_out.offset[10:5] == $past(req_in.wdata[5:0])))
        else $error("channel A upper gain or offset wrong");

    AST_CHAN_B_GAIN: assert property (
        (req_in.wr && req_in.addr == `DPOC_ADDR_B_CFG2 && !soft_reset_in) |=>
        (chan_b_out.gain_fine == $past(req_in.wdata[5:0])) &&
        (chan_b_out.gain_coarse[1:0] == $past(req_in.wdata[7:6])))
        else $error("channel B gain fields wrong");

    AST_SOFT_RESET: assert property (
        soft_reset_in |=> (osc_freq_word_out == '0) && (osc_phase_word_out == '0) &&
        (chan_a_out == '0) && (chan_b_out == '0) && (lp == `DPOC_RST_BYTE))
        else $error("interface reset left a register set");

    AST_RESERVED: assert property (
        (req_in.rd && req_in.addr == `DPOC_ADDR_LOOP) |=> (rdata_out[6] == 1'b0))
        else $error("reserved loop bit reads back set");

    AST_FREQ_BYTE0: assert property (
        (req_in.wr && req_in.addr == `DPOC_ADDR_FREQ0 && !soft_reset_in) |=>
        (osc_freq_word_out[7:0] == $past(req_in.wdata)) && $stable(osc_freq_word_out[31:8]))
        else $error("frequency low byte not written alone");

    AST_FREQ_BYTE1: assert property (
        (req_in.wr && req_in.addr == `DPOC_ADDR_FREQ1 && !soft_reset_in) |=>
        (osc_freq_word_out[15:8] == $past(req_in.wdata)) &&
        $stable({osc_freq_word_out[31:16], osc_freq_word_out[7:0]}))
        else $error("frequency second byte not written alone");

    AST_FREQ_BYTE2: assert property (
        (req_in.wr && req_in.addr == `DPOC_ADDR_FREQ2 && !soft_reset_in) |=>
        (osc_freq_word_out[23:16] == $past(req_in.wdata)) &&
        $stable({osc_freq_word_out[31:24], osc_freq_word_out[15:0]}))
        else $error("frequency third byte not written alone");

    AST_PHASE_HIGH: assert property (
        (req_in.wr && req_in.addr == `DPOC_ADDR_PH_HI && !soft_reset_in) |=>
        (osc_phase_word_out[15:8] == $past(req_in.wdata)) && $stable(osc_phase_word_out[7:0]))
        else $error("phase high byte not written alone");

    AST_CHAN_A_LOW: assert property (
        (req_in.wr && req_in.addr == `DPOC_ADDR_A_CFG2 && !soft_reset_in) |=>
        (chan_a_out.gain_fine == $past(req_in.wdata[5:0])) &&
        (chan_a_out.gain_coarse[1:0] == $past(req_in.wdata[7:6])) && $stable(chan_a_out.offset))
        else $error("channel A gain fields wrong");

    AST_CHAN_A_OFFSET: assert property (
        (req_in.wr && req_in.addr == `DPOC_ADDR_A_CFG3 && !soft_reset_in) |=>
        $stable(chan_a_out.offset[4:0]) && $stable(chan_a_out.gain_fine))
        else $error("channel A upper byte disturbed the low offset bits");

    AST_CHAN_B_CFG1: assert property (
        (req_in.wr && req_in.addr == `DPOC_ADDR_B_CFG1 && !soft_reset_in) |=>
        (chan_b_out.power_off == $past(req_in.wdata[7])) && (chan_b_out.sleep == $past(req_in.wdata[6])))
        else $error("channel B power or sleep wrong");

    AST_CHAN_B_OFFSET: assert property (
        (req_in.wr && req_in.addr == `DPOC_ADDR_B_CFG1 && !soft_reset_in) |=>
        (chan_b_out.offset[4:0] == $past(req_in.wdata[5:1])) && $stable(chan_b_out.offset[10:5]))
        else $error("channel B low offset bits wrong");

    AST_CHAN_B_HIGH: assert property (
        (req_in.wr && req_in.addr == `DPOC_ADDR_B_CFG3 && !soft_reset_in) |=>
        (chan_b_out.gain_coarse[3:2] == $past(req_in.wdata[7:6])) &&
        (chan_b_out.offset[10:5] == $past(req_in.wdata[5:0])))
        else $error("channel B upper gain or offset wrong");

    AST_DIV_INVALID: assert property (
        1'b1 |=> (loop_cfg_out.div_code_invalid == $past(lp[4:3] == 2'b11 && !lp[7])))
        else $error("invalid divider flag wrong");

    AST_DELAY_ZERO: assert property (
        (lp[4:3] == 2'b00) |=> (loop_cfg_out.clk_delay_ps == 10'd130) &&
        (loop_cfg_out.div_ratio == 4'h2))
        else $error("divider code 00 decoded wrongly");

    AST_PHASE_ZERO: assert property (
        (lp[2:1] == 2'b00) |=> (loop_cfg_out.phase_shift_deg == 9'd0))
        else $error("phase code 00 does not give zero degrees");

endmodule

//--- dpoc_cfg_bank_tb.sv
`timescale 1ns/1ns

module dpoc_cfg_bank_tb
    import dpoc_pkg::*;
;
    logic           clk_in;
    logic           rstn_in;
    logic           soft_reset_in;
    logic           osc_enable_in;
    logic           osc_low_power_sel_in;
    dpoc_reg_req_t  req;
    logic [7:0]     rdata;
    dpoc_loop_cfg_t loop_cfg;
    dpoc_chan_cfg_t chan_a;
    dpoc_chan_cfg_t chan_b;
    logic [31:0]    freq_word;
    logic [15:0]    ph_word;
    logic [15:0]    osc_ph;
    int             error_cnt = 0;
    int             n_checks = 0;
    int             cycles = 0;

    // =====================================================================
    // clock, design and host
    initial
    begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    dpoc_cfg_bank uut (
        .clk_in               (clk_in),
        .rstn_in              (rstn_in),
        .req_in               (req),
        .soft_reset_in        (soft_reset_in),
        .osc_enable_in        (osc_enable_in),
        .osc_low_power_sel_in (osc_low_power_sel_in),
        .rdata_out            (rdata),
        .loop_cfg_out         (loop_cfg),
        .chan_a_out           (chan_a),
        .chan_b_out           (chan_b),
        .osc_freq_word_out    (freq_word),
        .osc_phase_word_out   (ph_word),
        .osc_phase_out        (osc_ph)
    );

    dpoc_host_model host (
        .clk_in   (clk_in),
        .rdata_in (rdata),
        .req_out  (req)
    );

    // =====================================================================
    // comparisons and closing
    task automatic chk_out(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // register readback through the host
    task automatic chk_reg(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] got;
        host.rd(addr, got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected reg %h: expected %h, seen %h", addr, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // a hung handshake must not stall the run forever
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    // =====================================================================
    // scenarios
    task automatic t_reset();
        for (int a = 0; a < 16; a++)
            chk_reg(8'(a), 8'h00);
        chk_out("div ratio", 32'd2, 32'(loop_cfg.div_ratio));
        chk_out("clk delay", 32'd130, 32'(loop_cfg.clk_delay_ps));
        chk_out("chan a", 32'h0, 32'(chan_a));
    endtask

    // every divider and phase code with loop on, every delay code bypassed
    task automatic t_loop();
        logic [7:0] v;
        for (int lo = 0; lo < 2; lo++)
        begin
            for (int c = 0; c < 4; c++)
            begin
                v = {lo[0], 1'b1, ~c[0], c[1:0], c[1:0], c[0]};
                host.wr(8'h02, v);
                @(negedge clk_in);
                chk_out("loop off", 32'(lo[0]), 32'(loop_cfg.synth_loop_off));
                chk_out("div off", 32'(c[0] == 1'b0), 32'(loop_cfg.loop_divider_off));
                chk_out("edge inv", 32'(c[0]), 32'(loop_cfg.sample_clock_edge_invert));
                chk_reg(8'h02, v & 8'hbf);
                if (lo == 0)
                begin
                    chk_out("div ratio", (c == 3) ? 0 : (2 << c), 32'(loop_cfg.div_ratio));
                    chk_out("div bad", 32'(c == 3), 32'(loop_cfg.div_code_invalid));
                    chk_out("phase", (c == 3) ? 0 : 120 * c, 32'(loop_cfg.phase_shift_deg));
                end
                else
                    chk_out("clk delay", 130 + 150 * c, 32'(loop_cfg.clk_delay_ps));
            end
        end
    endtask

    // byte placement, and a rewrite touching only one byte
    task automatic t_words();
        for (int i = 0; i < 4; i++)
            host.wr(8'(3 + i), 8'(8'h11 * (i + 1)));
        chk_out("freq word", 32'h44332211, freq_word);
        host.wr(8'h04, 8'hc5);
        chk_out("freq word", 32'h4433c511, freq_word);
        host.wr(8'h07, 8'h5a);
        host.wr(8'h08, 8'ha6);
        chk_out("phase word", 32'h0000a65a, 32'(ph_word));
        chk_reg(8'h04, 8'hc5);
    endtask

    // both channels through a slow host; reserved bit 0 is written as 1
    task automatic t_chan();
        logic [7:0] v1;
        logic [7:0] v2;
        logic [7:0] v3;
        dpoc_chan_cfg_t e;
        host.gap = 2;
        for (int ch = 0; ch < 2; ch++)
        begin
            v1 = ch ? 8'h6d : 8'hb7;
            v2 = ch ? 8'h5e : 8'ha3;
            v3 = ch ? 8'h39 : 8'hc6;
            host.wr(ch ? 8'h0c : 8'h09, v1);
            host.wr(ch ? 8'h0d : 8'h0a, v2);
            host.wr(ch ? 8'h0e : 8'h0b, v3);
            e = '{power_off: v1[7], sleep: v1[6], offset: {v3[5:0], v1[5:1]},
                  gain_coarse: {v3[7:6], v2[7:6]}, gain_fine: v2[5:0]};
            if (ch == 0)
                chk_out("chan a cfg", 32'(e), 32'(chan_a));
            else
                chk_out("chan b cfg", 32'(e), 32'(chan_b));
            chk_reg(ch ? 8'h0c : 8'h09, v1 & 8'hfe);
        end
        host.gap = 0;
    endtask

    // accumulator clear, full rate step, then low-power step
    task automatic t_osc();
        logic [15:0] p;
        host.wr(8'h03, 8'h00);
        host.wr(8'h04, 8'h00);
        host.wr(8'h05, 8'h01);
        host.wr(8'h06, 8'h00);
        host.wr(8'h07, 8'h34);
        host.wr(8'h08, 8'h12);
        for (int lp = 0; lp < 2; lp++)
        begin
            osc_enable_in = 1'b0;
            osc_low_power_sel_in = lp[0];
            repeat (3) @(negedge clk_in);
            chk_out("osc cleared", lp ? 32'h1000 : 32'h1234, 32'(osc_ph));
            osc_enable_in = 1'b1;
            repeat (3) @(negedge clk_in);
            p = osc_ph;
            @(negedge clk_in);
            chk_out("osc step", 32'(p + (lp ? 16'h0800 : 16'h0001)), 32'(osc_ph));
            host.wr(8'h06, 8'h08);
        end
        osc_enable_in = 1'b0;
        osc_low_power_sel_in = 1'b0;
    endtask

    // interface reset clears the bank
    task automatic t_soft();
        host.wr(8'h09, 8'hff);
        soft_reset_in = 1'b1;
        @(negedge clk_in);
        soft_reset_in = 1'b0;
        chk_reg(8'h09, 8'h00);
        chk_reg(8'h06, 8'h00);
        chk_out("chan a", 32'h0, 32'(chan_a));
    endtask

    // =====================================================================
    // main sequence
    initial
    begin
        rstn_in = 1'b0;
        soft_reset_in = 1'b0;
        osc_enable_in = 1'b0;
        osc_low_power_sel_in = 1'b0;
        repeat (8) @(negedge clk_in);
        rstn_in = 1'b1;
        t_reset();
        t_loop();
        t_words();
        t_chan();
        t_osc();
        t_soft();
        wrap_up();
    end
endmodule

//--- dpoc_host_model.sv
`timescale 1ns/1ns

// =====================================================================
// serial host model: byte writes and reads on the register port
module dpoc_host_model
    import dpoc_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    output dpoc_reg_req_t   req_out
);
    int gap = 0; // idle cycles before each access, models a slow host

    // port idles released; the bank treats wr=rd=0 as no access
    initial req_out = '0;

    // one write strobe per byte, dropped before the next access
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        repeat (gap) @(negedge clk_in);
        @(negedge clk_in);
        req_out = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge clk_in);
        req_out = '0;
    endtask

    // read data lands at the edge that takes the strobe
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        repeat (gap) @(negedge clk_in);
        @(negedge clk_in);
        req_out = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge clk_in);
        req_out = '0;
        data = rdata_in;
    endtask
endmodule

//--- dpoc_osc_accum.sv
`timescale 1ns/1ns
`include "dpoc_regs.svh"

module dpoc_osc_accum #(
    parameter int ACC_W = 32,
    parameter int PH_W  = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    input  wire logic             osc_enable_in,
    input  wire logic             osc_low_power_sel_in,
    input  wire logic [ACC_W-1:0] freq_word_in,
    input  wire logic [PH_W-1:0]  phase_word_in,
    output logic [PH_W-1:0]       phase_out
);
    localparam int LP = `DPOC_LP_BITS;

    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] step;
    logic [PH_W-1:0]  ofs;
    logic [PH_W-1:0]  phase_r;

    // low power keeps only the top bits, which also keeps the adder toggling low
    assign step = osc_low_power_sel_in ? {freq_word_in[ACC_W-1 -: LP], {(ACC_W-LP){1'b0}}}
                                       : freq_word_in;
    assign ofs  = osc_low_power_sel_in ? {phase_word_in[PH_W-1 -: LP], {(PH_W-LP){1'b0}}}
                                       : phase_word_in;

    // phase accumulator, held at zero while disabled
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in || !osc_enable_in)
            acc_r <= '0;
        else
            acc_r <= acc_r + step;
    end

    // output phase, low bits blanked in low power mode
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            phase_r <= '0;
        else if (osc_low_power_sel_in)
            phase_r <= {acc_r[ACC_W-1 -: LP] + ofs[PH_W-1 -: LP], {(PH_W-LP){1'b0}}};
        else
            phase_r <= acc_r[ACC_W-1 -: PH_W] + ofs;
    end

    assign phase_out = phase_r;

    AST_OSC_CLEAR: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !osc_enable_in |=> (acc_r == '0))
        else $error("oscillator phase not cleared while disabled");

    AST_OSC_LP: assert property (@(posedge clk_in) disable iff (!rstn_in)
        osc_low_power_sel_in |=> (phase_out[PH_W-LP-1:0] == '0))
        else $error("low power phase uses more than the top bits");

endmodule

//--- dpoc_pkg.sv
package dpoc_pkg;

    // host access to the byte registers
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dpoc_reg_req_t;

    // decoded clock synthesis loop settings
    typedef struct packed {
        logic       synth_loop_off;
        logic       loop_divider_off;
        logic [3:0] div_ratio;
        logic       div_code_invalid;
        logic [9:0] clk_delay_ps;
        logic [8:0] phase_shift_deg;
        logic       sample_clock_edge_invert;
    } dpoc_loop_cfg_t;

    // per-channel analog core settings
    typedef struct packed {
        logic        power_off;
        logic        sleep;
        logic [10:0] offset;
        logic [3:0]  gain_coarse;
        logic [5:0]  gain_fine;
    } dpoc_chan_cfg_t;

    // index of each byte register inside the bank
    typedef enum logic [3:0] {
        IDX_LOOP, IDX_FREQ0, IDX_FREQ1, IDX_FREQ2, IDX_FREQ3, IDX_PH_LO, IDX_PH_HI,
        IDX_A_CFG1, IDX_A_CFG2, IDX_A_CFG3, IDX_B_CFG1, IDX_B_CFG2, IDX_B_CFG3
    } dpoc_reg_idx_t;

endpackage

//--- dpoc_regs.svh
`ifndef DPOC_REGS_SVH
`define DPOC_REGS_SVH

// =====================================================================
// register addresses of the bank
`define DPOC_ADDR_LOOP      8'h02
`define DPOC_ADDR_FREQ0     8'h03
`define DPOC_ADDR_FREQ1     8'h04
`define DPOC_ADDR_FREQ2     8'h05
`define DPOC_ADDR_FREQ3     8'h06
`define DPOC_ADDR_PH_LO     8'h07
`define DPOC_ADDR_PH_HI     8'h08
`define DPOC_ADDR_A_CFG1    8'h09
`define DPOC_ADDR_A_CFG2    8'h0a
`define DPOC_ADDR_A_CFG3    8'h0b
`define DPOC_ADDR_B_CFG1    8'h0c
`define DPOC_ADDR_B_CFG2    8'h0d
`define DPOC_ADDR_B_CFG3    8'h0e

// =====================================================================
// field positions
`define DPOC_LOOP_OFF_BIT   7
`define DPOC_DIV_OFF_BIT    5
`define DPOC_DIV_HI         4
`define DPOC_DIV_LO         3
`define DPOC_PHS_HI         2
`define DPOC_PHS_LO         1
`define DPOC_EDGE_BIT       0
`define DPOC_PWR_BIT        7
`define DPOC_SLEEP_BIT      6

// =====================================================================
// writable-bit masks and reset value
`define DPOC_MASK_LOOP      8'hbf
`define DPOC_MASK_CFG1      8'hfe
`define DPOC_MASK_FULL      8'hff
`define DPOC_RST_BYTE       8'h00

// =====================================================================
// decoded timing figures (ps), phase steps (degrees) and low power bit count
`define DPOC_DLY0_PS        10'd130
`define DPOC_DLY1_PS        10'd280
`define DPOC_DLY2_PS        10'd430
`define DPOC_DLY3_PS        10'd580
`define DPOC_PHS1_DEG       9'd120
`define DPOC_PHS2_DEG       9'd240
`define DPOC_LP_BITS        5

`endif
